// *** inc/sbf_pkg.sv ***
// Constants, types and helpers shared by both ends
`default_nettype none
package sbf_pkg;

  // ----------------------------------------------------------------
  // Transaction codes
  // ----------------------------------------------------------------
  localparam logic [3:0] TC_WR_BLOCK   = 4'h1;
  localparam logic [3:0] TC_RD_RESP_BL = 4'h7;
  localparam logic [3:0] TC_LOCK_REQ   = 4'h9;
  localparam logic [3:0] TC_ISO        = 4'ha;
  localparam logic [3:0] TC_LOCK_RESP  = 4'hb;

  // ----------------------------------------------------------------
  // Field values and positions
  // ----------------------------------------------------------------
  localparam logic [3:0]  PRIO_CABLE    = 4'h0;
  localparam logic [1:0]  TAG_FORMATTED = 2'h0;
  localparam int unsigned HDR_QUADS     = 4;
  localparam int unsigned QCNT_W        = 14;
  localparam logic [13:0] HDR_QCNT      = 14'h0004;
  localparam int unsigned RCODE_W       = 4;
  localparam int unsigned TRL_QCNT_LSB  = 16;
  localparam int unsigned TRL_ACK_LSB   = 8;
  localparam int unsigned TRL_SPD_LSB   = 4;
  localparam int unsigned HDR_PRIO_LSB  = 0;
  localparam int unsigned ISO_LEN_LSB   = 16;
  localparam int unsigned MOVER_SPD_LSB = 22;

  typedef enum logic [1:0] {RT_NEW = 2'h0, RT_RETRY_X = 2'h1, RT_RETRY_A = 2'h2, RT_RETRY_B = 2'h3} retry_t;
  typedef enum logic [1:0] {SPD_S100 = 2'h0, SPD_S200 = 2'h1, SPD_S400 = 2'h2, SPD_UNDEF = 2'h3} speed_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic has_block_data(input logic [3:0] tc);
    has_block_data = (tc == TC_WR_BLOCK) || (tc == TC_RD_RESP_BL) || (tc == TC_LOCK_REQ) || (tc == TC_LOCK_RESP);
  endfunction

  // Byte lane 0 is the most significant byte of a quadlet
  function automatic logic [31:0] put_byte(input logic [31:0] q, input logic [1:0] lane, input logic [7:0] b);
    logic [31:0] r;
    r = q;
    r[8 * (3 - int'(lane)) +: 8] = b;
    put_byte = r;
  endfunction

  function automatic logic [13:0] data_quads(input logic [15:0] len);
    logic [16:0] s;
    s = {1'b0, len} + 17'h00003;
    data_quads = 14'(s[16:2]);
  endfunction

  // Bytes that go into the next payload quadlet
  function automatic logic [2:0] chunk(input logic [15:0] left);
    chunk = (left > 16'h0003) ? 3'h4 : left[2:0];
  endfunction

endpackage
`default_nettype wire

// *** inc/sbf_link_if.sv ***
// Quadlet streams joining the device end and the host end
`timescale 1ns/100ps
`default_nettype none
interface sbf_link_if;
  logic        rxq_valid;  // Receive quadlet offered to host
  logic        rxq_ready;  // Host takes it
  logic [31:0] rxq_data;   // Header, payload or status quadlet
  logic        rxq_last;   // Status quadlet, ends packet
  logic        itq_valid;  // Iso transmit quadlet offered to device
  logic        itq_ready;  // Device takes it
  logic [31:0] itq_data;   // Iso header or payload quadlet

  modport dev (output rxq_valid, output rxq_data, output rxq_last, input rxq_ready,
               input itq_valid, input itq_data, output itq_ready);
  modport host (input rxq_valid, input rxq_data, input rxq_last, output rxq_ready,
                output itq_valid, output itq_data, input itq_ready);
endinterface
`default_nettype wire

// *** logic/sbf_device.sv ***
// Device end: block receive formatter and iso sender
//
// What this block does
// - Status quadlet reports header plus payload quadlets.
// - Status quadlet carries five-bit acknowledge code.
// - Destination is bus number then node number.
// - Retry code new, X, A, B encoded.
// - Priority field is zero on cable.
// - Destination offset is quadlet aligned.
// - Lock response: response code tops offset high.
// - Length counts block payload bytes only.
// - Payload starts byte zero, last quadlet padded.
// - Speed code 100, 200, 400, undefined.
// - Extended code names the block operation.
// - Transaction label passed unchanged for pairing.
// - Host queues iso packets in send order.
// - Waiting iso packets go after cycle start.
// - Iso speed from data mover control bits.
// - Host sets iso tag to formatted.
// - Host sets iso transaction code to A.
// - Iso header holds channel and sync bits.
// - Host puts payload from byte zero, pads.
// - Iso length decides how many bytes sent.
// - Each block packet ends with status quadlet.
`timescale 1ns/100ps
`default_nettype none
module sbf_device
  import sbf_pkg::*;
(
  input  wire logic        mclk_i,            // 10 MHz clock
  input  wire logic        rstn_i,            // Synchronous reset, active low
  sbf_link_if.dev          lnk,               // Streams to the host end
  input  wire logic        pkt_valid_i,       // Received packet header offered
  output logic             pkt_ready_o,       // Header taken
  input  wire logic [9:0]  dst_bus_i,         // Destination bus number
  input  wire logic [5:0]  dst_node_i,        // Destination node number
  input  wire logic [5:0]  tlabel_i,          // Transaction label
  input  wire retry_t      retry_i,           // Retry code
  input  wire logic [3:0]  tcode_i,           // Transaction code
  input  wire logic [15:0] src_id_i,          // Source node ID
  input  wire logic [47:0] dst_offset_i,      // Destination offset
  input  wire logic [3:0]  rcode_i,           // Response code of lock response
  input  wire logic [15:0] data_len_i,        // Block payload bytes
  input  wire logic [15:0] ext_tcode_i,       // Extended transaction code
  input  wire logic [4:0]  ack_status_code_i, // Acknowledge code for status
  input  wire speed_t      rx_spd_i,          // Speed of received packet
  input  wire logic        pay_valid_i,       // Payload byte offered
  output logic             pay_ready_o,       // Payload byte taken
  input  wire logic [7:0]  pay_byte_i,        // Payload byte, byte 0 first
  input  wire logic [31:0] data_mover_ctrl_i, // Data mover control value
  input  wire logic        cycle_start_i,     // Cycle start seen or sent
  output logic             iso_valid_o,       // Iso quadlet to the bus side
  input  wire logic        iso_ready_i,       // Bus side takes it
  output logic [31:0]      iso_data_o,        // Iso header or payload quadlet
  output logic             iso_last_o,        // Last quadlet of packet
  output var speed_t       iso_spd_o          // Speed of current iso packet
);

  // ----------------------------------------------------------------
  // Receive formatter
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_HDR, RX_DATA, RX_TRL} rx_state_t;

  rx_state_t          rx_st_q, rx_st_d;
  logic [31:0]        hdr_q [HDR_QUADS];
  logic [31:0]        hdr_d [HDR_QUADS];
  logic [31:0]        trl_q, trl_d;
  logic [1:0]         hidx_q, hidx_d;
  logic [15:0]        left_q, left_d;
  logic [31:0]        pk_q, pk_d;
  logic [2:0]         pkn_q, pkn_d;
  logic [31:0]        rq_q, rq_d;
  logic               rv_q, rv_d;
  logic               rl_q, rl_d;
  logic [2:0]         need;
  logic [QCNT_W-1:0]  qcnt;
  logic               adv;

  assign adv = !rv_q || lnk.rxq_ready;
  assign need = chunk(left_q);

  always_comb
  begin
    rx_st_d     = rx_st_q;
    hdr_d       = hdr_q;
    trl_d       = trl_q;
    hidx_d      = hidx_q;
    left_d      = left_q;
    pk_d        = pk_q;
    pkn_d       = pkn_q;
    rq_d        = rq_q;
    rl_d        = rl_q;
    rv_d        = rv_q && !lnk.rxq_ready;
    pkt_ready_o = 1'b0;
    pay_ready_o = 1'b0;
    qcnt        = HDR_QCNT;
    case (rx_st_q)
      RX_IDLE:
      begin
        pkt_ready_o = 1'b1;
        if (pkt_valid_i)
        begin
          hdr_d[0] = {dst_bus_i, dst_node_i, tlabel_i, retry_i, tcode_i, PRIO_CABLE};
          if (tcode_i == TC_LOCK_RESP)
            hdr_d[1] = {src_id_i, rcode_i, {(16 - RCODE_W){1'b0}}};
          else
            hdr_d[1] = {src_id_i, dst_offset_i[47:32]};
          hdr_d[2] = {dst_offset_i[31:2], 2'h0};
          hdr_d[3] = {data_len_i, ext_tcode_i};
          // Read requests and write responses carry no payload quadlets
          left_d = has_block_data(tcode_i) ? data_len_i : 16'h0000;
          if (has_block_data(tcode_i))
            qcnt = HDR_QCNT + data_quads(data_len_i);
          trl_d = '0;
          trl_d[TRL_QCNT_LSB +: QCNT_W] = qcnt;
          trl_d[TRL_ACK_LSB +: 5]       = ack_status_code_i;
          trl_d[TRL_SPD_LSB +: 2]       = rx_spd_i;
          hidx_d  = 2'h0;
          pk_d    = '0;
          pkn_d   = 3'h0;
          rx_st_d = RX_HDR;
        end
      end
      RX_HDR:
      begin
        if (adv)
        begin
          rq_d   = hdr_q[hidx_q];
          rv_d   = 1'b1;
          rl_d   = 1'b0;
          hidx_d = hidx_q + 2'h1;
          if (hidx_q == 2'h3)
            rx_st_d = (left_q != 16'h0000) ? RX_DATA : RX_TRL;
        end
      end
      RX_DATA:
      begin
        if (pkn_q != need)
        begin
          pay_ready_o = 1'b1;
          if (pay_valid_i)
          begin
            pk_d  = put_byte(pk_q, pkn_q[1:0], pay_byte_i);
            pkn_d = pkn_q + 3'h1;
          end
        end
        else if (adv)
        begin
          // Unfilled lanes of a short last quadlet stay zero
          rq_d   = pk_q;
          rv_d   = 1'b1;
          rl_d   = 1'b0;
          pk_d   = '0;
          pkn_d  = 3'h0;
          left_d = left_q - {13'h0000, need};
          if (left_q == {13'h0000, need})
            rx_st_d = RX_TRL;
        end
      end
      RX_TRL:
      begin
        if (adv)
        begin
          rq_d    = trl_q;
          rv_d    = 1'b1;
          rl_d    = 1'b1;
          rx_st_d = RX_IDLE;
        end
      end
      default:
        rx_st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      rx_st_q <= RX_IDLE;
      hdr_q   <= '{default: '0};
      trl_q   <= '0;
      hidx_q  <= 2'h0;
      left_q  <= 16'h0000;
      pk_q    <= '0;
      pkn_q   <= 3'h0;
      rq_q    <= '0;
      rv_q    <= 1'b0;
      rl_q    <= 1'b0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      hdr_q   <= hdr_d;
      trl_q   <= trl_d;
      hidx_q  <= hidx_d;
      left_q  <= left_d;
      pk_q    <= pk_d;
      pkn_q   <= pkn_d;
      rq_q    <= rq_d;
      rv_q    <= rv_d;
      rl_q    <= rl_d;
    end
  end

  assign lnk.rxq_valid = rv_q;
  assign lnk.rxq_data  = rq_q;
  assign lnk.rxq_last  = rl_q;

  // ----------------------------------------------------------------
  // Isochronous transmit
  // ----------------------------------------------------------------
  // A burst drains whatever the host has queued; a packet that shows up
  // after the queue ran dry waits for the next cycle start.
  typedef enum logic [1:0] {IT_IDLE, IT_BURST, IT_DATA} it_state_t;

  it_state_t    it_q, it_d;
  logic [31:0]  iq_q, iq_d;
  logic         iv_q, iv_d;
  logic         il_q, il_d;
  speed_t       ispd_q, ispd_d;
  logic [13:0]  iqn_q, iqn_d;
  logic [13:0]  qn;
  logic         iadv;
  logic         itq_rdy;

  assign iadv = !iv_q || iso_ready_i;
  assign qn   = data_quads(lnk.itq_data[ISO_LEN_LSB +: 16]);

  always_comb
  begin
    it_d    = it_q;
    iq_d    = iq_q;
    il_d    = il_q;
    ispd_d  = ispd_q;
    iqn_d   = iqn_q;
    iv_d    = iv_q && !iso_ready_i;
    itq_rdy = 1'b0;
    case (it_q)
      IT_IDLE:
      begin
        if (cycle_start_i)
          it_d = IT_BURST;
      end
      IT_BURST:
      begin
        itq_rdy = iadv;
        if (!lnk.itq_valid)
          it_d = IT_IDLE;
        else if (iadv)
        begin
          iq_d   = lnk.itq_data;
          iv_d   = 1'b1;
          ispd_d = speed_t'(data_mover_ctrl_i[MOVER_SPD_LSB +: 2]);
          iqn_d  = qn;
          il_d   = (qn == 14'h0000);
          if (qn != 14'h0000)
            it_d = IT_DATA;
        end
      end
      IT_DATA:
      begin
        itq_rdy = iadv;
        if (lnk.itq_valid && iadv)
        begin
          iq_d  = lnk.itq_data;
          iv_d  = 1'b1;
          iqn_d = iqn_q - 14'h0001;
          il_d  = (iqn_q == 14'h0001);
          if (iqn_q == 14'h0001)
            it_d = IT_BURST;
        end
      end
      default:
        it_d = IT_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      it_q   <= IT_IDLE;
      iq_q   <= '0;
      iv_q   <= 1'b0;
      il_q   <= 1'b0;
      ispd_q <= SPD_S100;
      iqn_q  <= 14'h0000;
    end
    else
    begin
      it_q   <= it_d;
      iq_q   <= iq_d;
      iv_q   <= iv_d;
      il_q   <= il_d;
      ispd_q <= ispd_d;
      iqn_q  <= iqn_d;
    end
  end

  assign lnk.itq_ready = itq_rdy;
  assign iso_valid_o   = iv_q;
  assign iso_data_o    = iq_q;
  assign iso_last_o    = il_q;
  assign iso_spd_o     = ispd_q;

endmodule
`default_nettype wire

// *** logic/sbf_host.sv ***
// Host end: receive drain and iso packet builder
`timescale 1ns/100ps
`default_nettype none
module sbf_host
  import sbf_pkg::*;
(
  input  wire logic        mclk_i,        // 10 MHz clock
  input  wire logic        rstn_i,        // Synchronous reset, active low
  sbf_link_if.host         lnk,           // Streams to the device end
  output logic             rxw_valid_o,   // Received quadlet held
  input  wire logic        rxw_ready_i,   // User takes it
  output logic [31:0]      rxw_data_o,    // Received quadlet
  output logic             rxw_status_o,  // Quadlet is the status quadlet
  output logic             pkt_done_o,    // Status quadlet arrived, one pulse
  output logic [4:0]       pkt_ack_o,     // Acknowledge code of last packet
  output var speed_t       pkt_spd_o,     // Speed of last packet
  output logic [13:0]      pkt_qcnt_o,    // Quadlet count of last packet
  output logic             prio_err_o,    // Priority not zero
  output logic             align_err_o,   // Offset not quadlet aligned
  output logic             cnt_err_o,     // Count disagrees with quadlets seen
  input  wire logic        iso_req_i,     // Start an iso packet
  output logic             iso_ready_o,   // Request taken
  input  wire logic [5:0]  iso_chan_i,    // Channel number
  input  wire logic [3:0]  iso_sy_i,      // Synchronization bits
  input  wire logic [15:0] iso_len_i,     // Payload bytes
  input  wire logic        isob_valid_i,  // Payload byte offered
  output logic             isob_ready_o,  // Payload byte taken
  input  wire logic [7:0]  isob_byte_i    // Payload byte, byte 0 first
);

  // ----------------------------------------------------------------
  // Receive drain and checks
  // ----------------------------------------------------------------
  logic [31:0] wq_q;
  logic        wv_q, ws_q, done_q;
  logic [13:0] widx_q, trl_cnt;
  logic [4:0]  ack_q;
  speed_t      spd_q;
  logic [13:0] qc_q;
  logic        pe_q, ae_q, ce_q;
  logic        take;

  assign lnk.rxq_ready = !wv_q || rxw_ready_i;
  assign take          = lnk.rxq_valid && lnk.rxq_ready;
  assign trl_cnt       = lnk.rxq_data[TRL_QCNT_LSB +: QCNT_W];

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      wq_q   <= '0;
      wv_q   <= 1'b0;
      ws_q   <= 1'b0;
      done_q <= 1'b0;
      widx_q <= 14'h0000;
      ack_q  <= 5'h00;
      spd_q  <= SPD_S100;
      qc_q   <= 14'h0000;
      pe_q   <= 1'b0;
      ae_q   <= 1'b0;
      ce_q   <= 1'b0;
    end
    else
    begin
      done_q <= take && lnk.rxq_last;
      if (rxw_ready_i)
        wv_q <= 1'b0;
      if (take)
      begin
        wq_q <= lnk.rxq_data;
        wv_q <= 1'b1;
        ws_q <= lnk.rxq_last;
        widx_q <= lnk.rxq_last ? 14'h0000 : widx_q + 14'h0001;
        if (widx_q == 14'h0000)
          pe_q <= lnk.rxq_data[HDR_PRIO_LSB +: 4] != PRIO_CABLE;
        if (widx_q == 14'h0002)
          ae_q <= lnk.rxq_data[1:0] != 2'h0;
        if (lnk.rxq_last)
        begin
          ack_q <= lnk.rxq_data[TRL_ACK_LSB +: 5];
          spd_q <= speed_t'(lnk.rxq_data[TRL_SPD_LSB +: 2]);
          qc_q  <= trl_cnt;
          ce_q  <= trl_cnt != widx_q;
        end
      end
    end
  end

  assign rxw_valid_o  = wv_q;
  assign rxw_data_o   = wq_q;
  assign rxw_status_o = ws_q;
  assign pkt_done_o   = done_q;
  assign pkt_ack_o    = ack_q;
  assign pkt_spd_o    = spd_q;
  assign pkt_qcnt_o   = qc_q;
  assign prio_err_o   = pe_q;
  assign align_err_o  = ae_q;
  assign cnt_err_o    = ce_q;

  // ----------------------------------------------------------------
  // Isochronous packet builder
  // ----------------------------------------------------------------
  // Requests are served one at a time, which keeps send order.
  typedef enum logic {HT_IDLE, HT_DATA} ht_state_t;

  ht_state_t   ht_q, ht_d;
  logic [31:0] oq_q, oq_d;
  logic        ov_q, ov_d;
  logic [15:0] left_q, left_d;
  logic [31:0] pk_q, pk_d;
  logic [2:0]  pkn_q, pkn_d;
  logic [2:0]  need;
  logic        oadv;

  assign oadv = !ov_q || lnk.itq_ready;
  assign need = chunk(left_q);

  always_comb
  begin
    ht_d         = ht_q;
    oq_d         = oq_q;
    left_d       = left_q;
    pk_d         = pk_q;
    pkn_d        = pkn_q;
    ov_d         = ov_q && !lnk.itq_ready;
    iso_ready_o  = 1'b0;
    isob_ready_o = 1'b0;
    case (ht_q)
      HT_IDLE:
      begin
        iso_ready_o = oadv;
        if (iso_req_i && oadv)
        begin
          oq_d   = {iso_len_i, TAG_FORMATTED, iso_chan_i, TC_ISO, iso_sy_i};
          ov_d   = 1'b1;
          left_d = iso_len_i;
          pk_d   = '0;
          pkn_d  = 3'h0;
          if (iso_len_i != 16'h0000)
            ht_d = HT_DATA;
        end
      end
      HT_DATA:
      begin
        if (pkn_q != need)
        begin
          isob_ready_o = 1'b1;
          if (isob_valid_i)
          begin
            pk_d  = put_byte(pk_q, pkn_q[1:0], isob_byte_i);
            pkn_d = pkn_q + 3'h1;
          end
        end
        else if (oadv)
        begin
          oq_d   = pk_q;
          ov_d   = 1'b1;
          pk_d   = '0;
          pkn_d  = 3'h0;
          left_d = left_q - {13'h0000, need};
          if (left_q == {13'h0000, need})
            ht_d = HT_IDLE;
        end
      end
      default:
        ht_d = HT_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      ht_q   <= HT_IDLE;
      oq_q   <= '0;
      ov_q   <= 1'b0;
      left_q <= 16'h0000;
      pk_q   <= '0;
      pkn_q  <= 3'h0;
    end
    else
    begin
      ht_q   <= ht_d;
      oq_q   <= oq_d;
      ov_q   <= ov_d;
      left_q <= left_d;
      pk_q   <= pk_d;
      pkn_q  <= pkn_d;
    end
  end

  assign lnk.itq_valid = ov_q;
  assign lnk.itq_data  = oq_q;

endmodule
`default_nettype wire

// *** tb/sbf_link_chk.sv ***
// Checks on the quadlet streams between the ends
`timescale 1ns/100ps
`default_nettype none
module sbf_link_chk
  import sbf_pkg::*;
(
  input wire logic        mclk_i,    // Clock
  input wire logic        rstn_i,    // Reset, active low
  input wire logic        rxq_valid, // Receive quadlet offered
  input wire logic        rxq_ready, // Receive quadlet taken
  input wire logic [31:0] rxq_data,  // Receive quadlet
  input wire logic        rxq_last,  // Status quadlet
  input wire logic        itq_valid, // Iso quadlet offered
  input wire logic        itq_ready, // Iso quadlet taken
  input wire logic [31:0] itq_data   // Iso quadlet
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------------------------------------
  // Position in the current packets
  // ------------------------------------------------------------
  logic [13:0] qi_q, il_q;
  logic [3:0]  tc_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rstn_i)
    begin
      qi_q <= 14'h0000;
      tc_q <= 4'h0;
      il_q <= 14'h0000;
    end
    else
    begin
      if (rxq_valid && rxq_ready)
      begin
        qi_q <= rxq_last ? 14'h0000 : qi_q + 14'h0001;
        if (qi_q == 14'h0000)
          tc_q <= rxq_data[7:4];
      end
      // Iso length rounds up to whole quadlets
      if (itq_valid && itq_ready)
        il_q <= (il_q == 14'h0000) ? 14'(({1'b0, itq_data[31:16]} + 17'h00003) >> 2) : il_q - 14'h0001;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_rx_hold;
    rxq_valid && !rxq_ready |=> rxq_valid && $stable(rxq_data) && $stable(rxq_last);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx quadlet moved in stall");
  property p_prio;
    rxq_valid && qi_q == 14'h0000 |-> rxq_data[3:0] == PRIO_CABLE;
  endproperty
  a_prio: assert property (p_prio) else $error("priority not zero");
  property p_align;
    rxq_valid && qi_q == 14'h0002 |-> rxq_data[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("offset unaligned");
  property p_rcode;
    rxq_valid && qi_q == 14'h0001 && tc_q == TC_LOCK_RESP |-> rxq_data[11:0] == 12'h000;
  endproperty
  a_rcode: assert property (p_rcode) else $error("lock reserved bits set");
  property p_count;
    rxq_valid && rxq_last |-> rxq_data[29:16] == qi_q && qi_q >= 14'h0004;
  endproperty
  a_count: assert property (p_count) else $error("status count wrong");
  property p_trl;
    rxq_valid && rxq_last |-> {rxq_data[31:30], rxq_data[15:13], rxq_data[7:6], rxq_data[3:0]} == 11'h000;
  endproperty
  a_trl: assert property (p_trl) else $error("status layout wrong");
  property p_iso_hdr;
    itq_valid && il_q == 14'h0000 |-> itq_data[7:4] == TC_ISO && itq_data[15:14] == TAG_FORMATTED;
  endproperty
  a_iso_hdr: assert property (p_iso_hdr) else $error("iso code or tag wrong");
  property p_it_hold;
    itq_valid && !itq_ready |=> itq_valid && $stable(itq_data);
  endproperty
  a_it_hold: assert property (p_it_hold) else $error("iso quadlet moved in stall");
  c_lock: cover property (rxq_valid && rxq_ready && qi_q == 14'h0001 && tc_q == TC_LOCK_RESP);
  c_status: cover property (rxq_valid && rxq_ready && rxq_last);
  c_iso: cover property (itq_valid && itq_ready && il_q == 14'h0000);
endmodule
`default_nettype wire

// *** tb/serial_bus_block_rx_iso_tx_format_tb.sv ***
// Bench: both ends against a queue model
`timescale 1ns/100ps
`default_nettype none
module serial_bus_block_rx_iso_tx_format_tb;
  import sbf_pkg::*;
  localparam logic [3:0] TCS [8] = '{TC_WR_BLOCK, TC_RD_RESP_BL, TC_LOCK_REQ, TC_LOCK_RESP, 4'h0, 4'h4, 4'h5, 4'h6};
  logic        mclk_i = 1'b0, rstn_i = 1'b0, pkt_valid_i = 1'b0, pay_valid_i = 1'b0, cycle_start_i = 1'b0;
  logic        iso_ready_i = 1'b0, rxw_ready_i = 1'b0, iso_req_i = 1'b0, isob_valid_i = 1'b0;
  logic [9:0]  dst_bus_i;
  logic [5:0]  dst_node_i, tlabel_i, iso_chan_i;
  logic [3:0]  tcode_i, rcode_i, iso_sy_i;
  logic [15:0] src_id_i, data_len_i, ext_tcode_i, iso_len_i;
  logic [47:0] dst_offset_i;
  logic [4:0]  ack_status_code_i, pkt_ack_o;
  logic [7:0]  pay_byte_i, isob_byte_i;
  logic [31:0] data_mover_ctrl_i, iso_data_o, rxw_data_o;
  retry_t      retry_i;
  speed_t      rx_spd_i, iso_spd_o, pkt_spd_o;
  logic        pkt_ready_o, pay_ready_o, iso_valid_o, iso_last_o, rxw_valid_o, rxw_status_o, pkt_done_o;
  logic        prio_err_o, align_err_o, cnt_err_o, iso_ready_o, isob_ready_o;
  logic [13:0] pkt_qcnt_o;
  logic [32:0] rxq_exp[$], isoq_exp[$];
  logic [20:0] sts_exp[$];
  int          err_count = 0, check_count = 0, cyc = 0;

  sbf_link_if lnk ();
  sbf_device u_sbf_device (.mclk_i, .rstn_i, .lnk, .pkt_valid_i, .pkt_ready_o, .dst_bus_i, .dst_node_i, .tlabel_i,
    .retry_i, .tcode_i, .src_id_i, .dst_offset_i, .rcode_i, .data_len_i, .ext_tcode_i, .ack_status_code_i, .rx_spd_i,
    .pay_valid_i, .pay_ready_o, .pay_byte_i, .data_mover_ctrl_i, .cycle_start_i, .iso_valid_o, .iso_ready_i,
    .iso_data_o, .iso_last_o, .iso_spd_o);
  sbf_host u_sbf_host (.mclk_i, .rstn_i, .lnk, .rxw_valid_o, .rxw_ready_i, .rxw_data_o, .rxw_status_o, .pkt_done_o,
    .pkt_ack_o, .pkt_spd_o, .pkt_qcnt_o, .prio_err_o, .align_err_o, .cnt_err_o, .iso_req_i, .iso_ready_o,
    .iso_chan_i, .iso_sy_i, .iso_len_i, .isob_valid_i, .isob_ready_o, .isob_byte_i);
  sbf_link_chk u_chk (.mclk_i, .rstn_i, .rxq_valid(lnk.rxq_valid), .rxq_ready(lnk.rxq_ready),
    .rxq_data(lnk.rxq_data), .rxq_last(lnk.rxq_last), .itq_valid(lnk.itq_valid), .itq_ready(lnk.itq_ready),
    .itq_data(lnk.itq_data));

  always #50 mclk_i = ~mclk_i;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Packs bytes from lane 0 down, zero padding the tail
  task automatic push_pay(ref logic [32:0] q[$], input logic [7:0] pb[$]);
    logic [31:0] w;
    w = '0;
    foreach (pb[k])
    begin
      w[31 - 8 * (k % 4) -: 8] = pb[k];
      if (k % 4 == 3 || k == pb.size() - 1)
      begin
        q.push_back({1'b0, w});
        w = '0;
      end
    end
  endtask

  task automatic send_rx(input int i);
    logic [7:0]  pb[$];
    logic [31:0] q1;
    @(posedge mclk_i);
    #1;
    {dst_bus_i, dst_node_i, tlabel_i, src_id_i, dst_offset_i, rcode_i, ext_tcode_i, ack_status_code_i} =
      111'({$urandom, $urandom, $urandom, $urandom});
    retry_i = retry_t'(2'(i));
    rx_spd_i = speed_t'(2'(i / 4));
    tcode_i = TCS[i % 8];
    data_len_i = 16'($urandom_range(9));
    pkt_valid_i = 1'b1;
    q1 = (tcode_i == TC_LOCK_RESP) ? {src_id_i, rcode_i, 12'h000} : {src_id_i, dst_offset_i[47:32]};
    rxq_exp.push_back({1'b0, dst_bus_i, dst_node_i, tlabel_i, retry_i, tcode_i, PRIO_CABLE});
    rxq_exp.push_back({1'b0, q1});
    rxq_exp.push_back({1'b0, dst_offset_i[31:2], 2'h0});
    rxq_exp.push_back({1'b0, data_len_i, ext_tcode_i});
    if (i % 8 < 4)
      repeat (data_len_i) pb.push_back(8'($urandom));
    push_pay(rxq_exp, pb);
    q1 = 32'(4 + (pb.size() + 3) / 4);
    rxq_exp.push_back({3'h4, q1[13:0], 3'h0, ack_status_code_i, 2'h0, rx_spd_i, 4'h0});
    sts_exp.push_back({q1[13:0], ack_status_code_i, rx_spd_i});
    do @(negedge mclk_i); while (!pkt_ready_o);
    @(posedge mclk_i);
    #1;
    pkt_valid_i = 1'b0;
    foreach (pb[k])
    begin
      pay_valid_i = 1'b1;
      pay_byte_i = pb[k];
      do @(negedge mclk_i); while (!pay_ready_o);
      @(posedge mclk_i);
      #1;
    end
    pay_valid_i = 1'b0;
  endtask

  task automatic send_iso(input int i);
    logic [7:0] pb[$];
    @(posedge mclk_i);
    #1;
    {iso_chan_i, iso_sy_i, data_mover_ctrl_i} = 42'({$urandom, $urandom});
    iso_len_i = 16'((i % 2) ? $urandom_range(12) : 4 * (i % 3));
    iso_req_i = 1'b1;
    isoq_exp.push_back({1'b0, iso_len_i, TAG_FORMATTED, iso_chan_i, TC_ISO, iso_sy_i});
    repeat (iso_len_i) pb.push_back(8'($urandom));
    push_pay(isoq_exp, pb);
    isoq_exp[$][32] = 1'b1;
    do @(negedge mclk_i); while (!iso_ready_o);
    @(posedge mclk_i);
    #1;
    iso_req_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    chk(iso_valid_o, 1'b0);
    cycle_start_i = 1'b1;
    @(posedge mclk_i);
    #1;
    cycle_start_i = 1'b0;
    foreach (pb[k])
    begin
      isob_valid_i = 1'b1;
      isob_byte_i = pb[k];
      do @(negedge mclk_i); while (!isob_ready_o);
      @(posedge mclk_i);
      #1;
    end
    isob_valid_i = 1'b0;
    while (isoq_exp.size() != 0) @(posedge mclk_i);
  endtask

  // Random stalls on both consumer sides
  always @(posedge mclk_i)
  begin
    #1;
    rxw_ready_i = $urandom_range(3) != 0;
    iso_ready_i = $urandom_range(3) != 0;
  end

  always @(negedge mclk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      summarize();
    end
    else if (rstn_i)
    begin
      if (rxw_valid_o && rxw_ready_i)
        chk({rxw_status_o, rxw_data_o}, rxq_exp.pop_front());
      if (pkt_done_o)
        chk({pkt_qcnt_o, pkt_ack_o, pkt_spd_o, prio_err_o, align_err_o, cnt_err_o}, {sts_exp.pop_front(), 3'h0});
      if (iso_valid_o && iso_ready_i)
        chk({iso_spd_o, iso_last_o, iso_data_o}, {data_mover_ctrl_i[23:22], isoq_exp.pop_front()});
    end
  end

  initial
  begin
    void'($urandom(31937));
    repeat (10) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    for (int i = 0; i < 32; i++)
      send_rx(i);
    for (int i = 0; i < 8; i++)
      send_iso(i);
    while (rxq_exp.size() != 0) @(posedge mclk_i);
    repeat (5) @(posedge mclk_i);
    summarize();
  end
endmodule
`default_nettype wire
